//--- bench/dma_checker.sv
// Concurrent checks on the DMA controller ports
`timescale 1ns/10ps
module dma_checker
    import dma_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       ack_o,
    input wire mem_req_t   mem_o,
    input wire mem_rsp_t   mem_i,
    input wire logic [1:0] rx_ready_i,
    input wire logic [1:0] rx_pop_o,
    input wire logic [1:0] tx_push_o,
    input wire logic [1:0] tx_last_o,
    input wire logic [3:0] irq_o
);
    // One clock domain, so one default clock and reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Register bus handshake
    ack_answer_a: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o) else $error("no bus answer");
    ack_pulse_a: assert property (
        ack_o |=> !ack_o) else $error("bus answer too long");
    // Memory request, address, direction and write data held until answered
    req_hold_a: assert property (mem_o.req && !mem_i.ack |=>
        mem_o.req && $stable(mem_o.addr) && $stable(mem_o.we)
        && $stable(mem_o.wdata)) else $error("memory request changed");
    // Direction per channel is fixed; one channel served at a time, pops and last flags qualified, idle after reset
    pop_write_a: assert property (
        |rx_pop_o |-> mem_i.ack && mem_o.req && mem_o.we)
        else $error("receive pop without memory write");
    push_read_a: assert property (
        |tx_push_o |-> $past(mem_i.ack && mem_o.req && !mem_o.we))
        else $error("transmit push without memory read");
    one_grant_a: assert property (
        $onehot0({rx_pop_o, tx_push_o})) else $error("two channels served");
    pop_ready_a: assert property (
        (rx_pop_o & ~rx_ready_i) == 2'h0) else $error("pop with empty rx");
    last_push_a: assert property (
        (tx_last_o & ~tx_push_o) == 2'h0) else $error("last without push");
    reset_idle_a: assert property ($past(rst_i) |->
        !mem_o.req && irq_o == 4'h0 && !ack_o) else $error("busy after reset");
    // Main scenarios reached
    cover property (|rx_pop_o);
    cover property (|tx_push_o);
    cover property ($rose(|irq_o));
    cover property (|tx_last_o);
endmodule : dma_checker

//--- bench/mem_model.sv
// Behavioural system memory answering the DMA memory port
`timescale 1ns/10ps
module mem_model
    import dma_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire mem_req_t   req_i,
    input  wire logic [3:0] lat_i,
    output mem_rsp_t        rsp_o
);
    logic        ack;
    logic [3:0]  wait_cnt;
    logic [23:0] last_addr;
    // Insert lat_i wait states, then pulse ack once per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
            wait_cnt <= 4'h0;
            last_addr <= 24'h000000;
        end else if (req_i.req && !ack && wait_cnt == lat_i) begin
            ack <= 1'b1;
            wait_cnt <= 4'h0;
            last_addr <= req_i.addr;
        end else begin
            ack <= 1'b0;
            if (req_i.req && !ack)
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // Data follows the address; off the ack it is inverted, never stale.
    // Descriptors come from the same map: the word at A holds link
    // A[23:16] and length A[15:0], the word at A+4 the buffer A+4
    assign rsp_o = ack ? {1'b1, 8'h00, last_addr}
                       : {1'b0, 8'hFF, ~last_addr};
endmodule : mem_model

//--- bench/tb_top.sv
// Self-checking bench for the serial channel DMA controller
`timescale 1ns/10ps
module tb_top
    import dma_pkg::*;
;
    logic             clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
    logic [7:0]       adr_i;
    logic [31:0]      dat_i, dat_o, rd;
    logic [3:0]       sel_i, irq_o, lat;
    mem_req_t         mem_o;
    mem_rsp_t         mem_i;
    logic [1:0]       rx_ready_i, rx_last_i, rx_pop_o;
    logic [1:0]       tx_space_i, tx_push_o, tx_last_o;
    logic [1:0][15:0] rx_data_i;
    logic [15:0]      tx_data_o;
    logic [40:0]      mq[$];
    logic [17:0]      tq[$];
    int               n_fail, compares, i;

    serial_channel_dma_controller u_serial_channel_dma_controller (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .ack_o(ack_o), .mem_o(mem_o), .mem_i(mem_i),
        .rx_ready_i(rx_ready_i), .rx_data_i(rx_data_i),
        .rx_last_i(rx_last_i), .rx_pop_o(rx_pop_o),
        .tx_space_i(tx_space_i), .tx_data_o(tx_data_o),
        .tx_push_o(tx_push_o), .tx_last_o(tx_last_o), .irq_o(irq_o));
    mem_model u_mem_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_o),
        .lat_i(lat), .rsp_o(mem_i));

    // Clock at 50 MHz
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Log memory cycles and pushes; advance rx data once consumed
    // Receive data restarts under reset, so only this process drives it
    always @(posedge clk_i) begin
        if (rst_i)
            rx_data_i <= {16'h0050, 16'h00A0};
        if (mem_o.req && mem_i.ack)
            mq.push_back({mem_o.we, mem_o.addr, mem_o.wdata});
        if (|tx_push_o)
            tq.push_back({tx_last_o, tx_data_o});
        if (rx_pop_o[0])
            rx_data_i[0] <= rx_data_i[0] + 16'h0001;
        if (rx_pop_o[1])
            rx_data_i[1] <= rx_data_i[1] + 16'h0001;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Classic Wishbone cycle; read data lands in rd
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    function automatic logic [7:0] ra(input logic [1:0] ch,
                                      input logic [2:0] idx);
        return {1'b0, ch, idx, 2'b00};
    endfunction : ra
    // Address bytes and count, only legal in the initial state
    task automatic load(input logic [1:0] ch, input logic [23:0] a,
                        input logic [15:0] n);
        wb(1'b1, ra(ch, REG_ADDR_LOW), {24'h0, a[7:0]});
        wb(1'b1, ra(ch, REG_ADDR_MID), {24'h0, a[15:8]});
        wb(1'b1, ra(ch, REG_ADDR_BANK), {24'h0, a[23:16]});
        wb(1'b1, ra(ch, REG_COUNT), {16'h0, n});
    endtask : load
    // Poll until the channel is back in the initial state
    task automatic wait_init(input logic [1:0] ch);
        int k;
        k = 0;
        do begin
            wb(1'b0, ra(ch, REG_COMMAND), 32'h0);
            k++;
        end while (rd[5:4] !== 2'b00 && k < 300);
        chk({30'h0, rd[5:4]}, 32'h0);
    endtask : wait_init
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // Cut a hang short; the run needs far fewer cycles
    initial begin
        #(CLK_PERIOD_NS * 40000);
        n_fail++;
        close_out();
    end
    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
        sel_i = 4'h3;
        {rx_ready_i, rx_last_i} = 4'h0;
        tx_space_i = 2'b11;
        lat = 4'h2;
        n_fail = 0;
        compares = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Idle after reset, unmapped address reads zero
        wb(1'b0, ra(2'h3, REG_COMMAND), 32'h0);
        chk(rd & 32'hB0, 32'h0);
        wb(1'b0, 8'h84, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        // Receive block in bytes with wait states
        load(2'h0, 24'h123456, 16'h0003);
        wb(1'b1, ra(2'h0, REG_COMMAND), 32'h101);
        rx_ready_i <= 2'b01;
        wait_init(2'h0);
        rx_ready_i <= 2'b00;
        chk(mq.size(), 3);
        for (i = 0; i < 3; i++) begin
            chk(mq[i][39:16], 24'h123456 + i);
            chk({mq[i][40], mq[i][7:0]}, {1'b1, 8'hA0 + i[7:0]});
        end
        wb(1'b0, ra(2'h0, REG_COMMAND), 32'h0);
        chk(rd & 32'hB0, 32'h80);
        chk({28'h0, irq_o}, 32'h1);
        wb(1'b0, ra(2'h0, REG_ADDR_LOW), 32'h0);
        chk(rd[7:0], 8'h59);
        wb(1'b0, ra(2'h0, REG_COUNT), 32'h0);
        chk(rd[15:0], 16'h0);
        wb(1'b1, ra(2'h0, REG_COMMAND), 32'h80);
        chk({28'h0, irq_o}, 32'h0);
        $display("receive test done");
        // Transmit block in words, zero wait states
        mq.delete();
        lat <= 4'h0;
        load(2'h1, 24'h001000, 16'h0004);
        wb(1'b1, ra(2'h1, REG_COMMAND), 32'h005);
        wait_init(2'h1);
        chk(mq.size() + tq.size(), 4);
        for (i = 0; i < 2; i++) begin
            chk({mq[i][40], mq[i][39:16]}, 24'h001000 + 2 * i);
            chk(tq[i], 16'h1000 + 2 * i);
        end
        $display("transmit test done");
        // Priority between two receivers, loads refused when enabled
        mq.delete();
        load(2'h0, 24'h000100, 16'h0001);
        load(2'h2, 24'h000200, 16'h0001);
        wb(1'b1, 8'h80, 32'h30);
        wb(1'b1, ra(2'h0, REG_COMMAND), 32'h001);
        wb(1'b1, ra(2'h2, REG_COMMAND), 32'h001);
        wb(1'b1, ra(2'h2, REG_ADDR_LOW), 32'hEE);
        wb(1'b0, ra(2'h2, REG_ADDR_LOW), 32'h0);
        chk(rd[7:0], 8'h00);
        wb(1'b0, ra(2'h2, REG_COMMAND), 32'h0);
        chk({30'h0, rd[5:4]}, 32'h1);
        rx_ready_i <= 2'b11;
        wait_init(2'h0);
        wait_init(2'h2);
        rx_ready_i <= 2'b00;
        chk(mq[0][39:16], 24'h000200);
        chk(mq[1][39:16], 24'h000100);
        $display("priority test done");
        // Halt keeps the channel, abort returns it to initial
        load(2'h2, 24'h000300, 16'h0002);
        wb(1'b1, ra(2'h2, REG_COMMAND), 32'h001);
        wb(1'b1, ra(2'h2, REG_COMMAND), 32'h000);
        wb(1'b0, ra(2'h2, REG_COMMAND), 32'h0);
        chk({30'h0, rd[5:4]}, 32'h2);
        wb(1'b1, ra(2'h2, REG_COMMAND), 32'h008);
        wait_init(2'h2);
        $display("halt test done");
        // One-entry chain on a transmitter; serial side framed bit-sync
        mq.delete();
        wb(1'b1, ra(2'h1, REG_DESC_BASE), 32'h0);
        wb(1'b1, ra(2'h1, REG_CUR_DESC), 32'h2);
        wb(1'b1, ra(2'h1, REG_END_DESC), 32'h0);
        wb(1'b1, ra(2'h1, REG_COMMAND), 32'h207);
        wait_init(2'h1);
        chk(mq.size(), 3);
        chk(mq[0][39:16], 24'h000002);
        chk(mq[2][39:16], 24'h000006);
        chk(tq[2], {2'b01, 16'h0006});
        wb(1'b0, ra(2'h1, REG_COMMAND), 32'h0);
        chk(rd & 32'hF0, 32'hC0);
        chk({28'h0, irq_o}, 32'h2);
        wb(1'b0, ra(2'h1, REG_CUR_DESC), 32'h0);
        chk(rd[15:0], 16'h0);
        wb(1'b1, ra(2'h1, REG_ADDR_LOW), 32'hEE);
        wb(1'b0, ra(2'h1, REG_ADDR_LOW), 32'h0);
        chk(rd[7:0], 8'h08);
        $display("chain test done");
        close_out();
    end
endmodule : tb_top

bind serial_channel_dma_controller dma_checker u_dma_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .mem_o(mem_o), .mem_i(mem_i),
    .rx_ready_i(rx_ready_i), .rx_pop_o(rx_pop_o),
    .tx_push_o(tx_push_o), .tx_last_o(tx_last_o), .irq_o(irq_o));

//--- core/dma_pkg.sv
// Shared constants and carrier types for the serial channel DMA controller
package dma_pkg;
    localparam int NUM_CH = 4;
    // Register index inside a channel window: adr_i[4:2], channel adr_i[6:5]
    localparam logic [2:0] REG_ADDR_LOW  = 3'h0;
    localparam logic [2:0] REG_ADDR_MID  = 3'h1;
    localparam logic [2:0] REG_ADDR_BANK = 3'h2;
    localparam logic [2:0] REG_COUNT     = 3'h3;
    localparam logic [2:0] REG_CUR_DESC  = 3'h4;
    localparam logic [2:0] REG_END_DESC  = 3'h5;
    localparam logic [2:0] REG_DESC_BASE = 3'h6;
    localparam logic [2:0] REG_COMMAND   = 3'h7;
    // Global priority register, word index on adr_i[7:2]
    localparam logic [5:0] REG_PRIORITY  = 6'h20;
    // Command register fields
    localparam int CMD_ENABLE   = 0;
    localparam int CMD_CHAIN    = 1;
    localparam int CMD_WORD     = 2;
    localparam int CMD_ABORT    = 3;
    localparam int CMD_FRAME    = 6;
    localparam int CMD_DONE     = 7;
    localparam int CMD_DONE_IE  = 8;
    localparam int CMD_FRAME_IE = 9;
    // Step sizes
    localparam logic [15:0] SZ_BYTE   = 16'h0001;
    localparam logic [15:0] SZ_WORD   = 16'h0002;
    localparam logic [23:0] DESC_STEP = 24'h000004;
    // Clock figure: 50 MHz, one memory cycle per three clocks at best
    localparam int CLK_PERIOD_NS = 20;

    typedef enum logic [1:0] {CH_INIT, CH_ENABLE, CH_HALT} ch_state_t;
    typedef enum logic [1:0] {E_IDLE, E_XFER, E_DESC0, E_DESC1} eng_t;

    // Memory request carrier
    typedef struct packed {
        logic        req;
        logic        we;
        logic        word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } mem_req_t;

    // Memory answer carrier
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } mem_rsp_t;
endpackage : dma_pkg

//--- core/serial_channel_dma_controller.sv
// Four-channel DMA controller between serial channel buffers and memory
// How it works
// R1: Four channels: 0/1 serve serial channel 0 rx/tx, 2/3 channel 1.
// R2: Even channels write memory from receiver; odd read memory to transmitter.
// R3: Single-block moves the programmed count, then returns to initial state.
// R4: Address is 24 bits from low, mid and bank byte subregisters.
// R5: Each memory cycle moves one byte or one word, single addressing.
// R6: Data moves only on a request while enabled, after initial loading.
// R7: Requests come from serial buffer fill status, not external pins.
// R8: Software sets relative channel priority, in both modes.
// R9: Interrupt on block completion; in chained mode also per frame.
// R10: Up to 11.1 MB/s at 16.7 MHz with zero-wait memory.
// R11: Software uses chained mode only with bit-synchronous framing.
// R12: Chained mode moves frames, then returns to initial state.
// R13: Software builds descriptors holding buffer address and next link.
// R14: Chained mode writes or reads buffers sequentially along the chain.
// R15: Finished buffers may be refilled while the channel stays enabled.
// R16: States initial, enabled, halted; addresses load only when initial.
// R17: In chained mode address registers track access; writes ignored.
// R18: Address subregisters need no defined value after reset.
// R19: Counter drops 1 per byte, 2 per word; stops at zero; zero means 64K.
// R20: Chained transfer stops when current descriptor equals end descriptor.
// R21: Transmit channels use the address subregisters as 24-bit source.
// R22: Done flag set on success, cleared by writing one, gated to interrupt.
// R23: One memory cycle at a time goes to the highest priority requester.
// R24: Address advances after each memory cycle by the bytes moved.
`timescale 1ns/10ps
module serial_channel_dma_controller
    import dma_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Wishbone register slave
    input  wire logic [7:0]       adr_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    input  wire logic             we_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    output logic                  ack_o,
    // Memory master
    output mem_req_t              mem_o,
    input  wire mem_rsp_t         mem_i,
    // Serial receivers
    input  wire logic [1:0]       rx_ready_i,
    input  wire logic [1:0][15:0] rx_data_i,
    input  wire logic [1:0]       rx_last_i,
    output logic      [1:0]       rx_pop_o,
    // Serial transmitters
    input  wire logic [1:0]       tx_space_i,
    output logic      [15:0]      tx_data_o,
    output logic      [1:0]       tx_push_o,
    output logic      [1:0]       tx_last_o,
    // Per-channel interrupt requests
    output logic      [3:0]       irq_o
);

    // Whole state of the block
    typedef struct packed {
        ch_state_t [3:0]        cst;
        logic      [3:0][23:0]  addr;
        logic      [3:0][15:0]  cnt;
        logic      [3:0][15:0]  cdp;
        logic      [3:0][15:0]  edp;
        logic      [3:0][7:0]   cpb;
        logic      [3:0]        chain;
        logic      [3:0]        word;
        logic      [3:0]        need;
        logic      [3:0]        done;
        logic      [3:0]        frame;
        logic      [3:0]        die;
        logic      [3:0]        fie;
        logic      [7:0]        prio;
        eng_t                   eng;
        logic      [1:0]        gnt;
        mem_req_t               mem;
        logic      [15:0]       dnext;
        logic      [15:0]       txd;
        logic      [1:0]        txp;
        logic      [1:0]        txl;
        logic                   ack;
        logic      [31:0]       dat;
    } state_t;

    state_t     s;
    state_t     next_s;
    logic [1:0] rx_pop;

    // Next-state logic: bus slave first, engine second, so that a
    // hardware set in the same cycle as a software clear wins
    always_comb begin
        logic [3:0]  want;
        logic [1:0]  win;
        logic [1:0]  best;
        logic        found;
        logic [15:0] sz;
        logic [1:0]  c;
        logic [2:0]  r;
        logic [1:0]  g;
        logic        idle;
        logic        wr;
        logic        last;
        logic [31:0] rd;
        next_s = s;
        want   = '0;
        win    = '0;
        best   = '0;
        found  = 1'b0;
        sz     = SZ_BYTE;
        c      = adr_i[6:5];
        r      = adr_i[4:2];
        g      = s.gnt;
        idle   = (s.cst[c] == CH_INIT);
        wr     = 1'b0;
        last   = 1'b0;
        rd     = '0;
        rx_pop = '0;
        next_s.txp = '0;
        next_s.txl = '0;

        // Wishbone: ack one cycle after the strobe, dropped the next
        next_s.ack = cyc_i & stb_i & ~s.ack;
        wr = next_s.ack & we_i;
        if (adr_i[7]) begin
            if (adr_i[7:2] == REG_PRIORITY) begin
                rd = {24'h0, s.prio};
            end
        end else begin
            case (r)
                REG_ADDR_LOW:  rd = {24'h0, s.addr[c][7:0]};
                REG_ADDR_MID:  rd = {24'h0, s.addr[c][15:8]};
                REG_ADDR_BANK: rd = {24'h0, s.addr[c][23:16]};
                REG_COUNT:     rd = {16'h0, s.cnt[c]};
                REG_CUR_DESC:  rd = {16'h0, s.cdp[c]};
                REG_END_DESC:  rd = {16'h0, s.edp[c]};
                REG_DESC_BASE: rd = {24'h0, s.cpb[c]};
                REG_COMMAND:   rd = {22'h0, s.fie[c], s.die[c], s.done[c],
                                     s.frame[c], s.cst[c], 1'b0, s.word[c],
                                     s.chain[c], s.cst[c] == CH_ENABLE};
                default:       rd = '0;
            endcase
        end
        if (next_s.ack) begin
            next_s.dat = rd;
        end

        // Register writes
        if (wr && adr_i[7:2] == REG_PRIORITY && sel_i[0]) begin
            next_s.prio = dat_i[7:0]; // [R8]
        end else if (wr && !adr_i[7]) begin
            case (r)
                // Address loads only while initial, never in chained mode
                REG_ADDR_LOW: begin
                    if (idle && !s.chain[c] && sel_i[0]) begin
                        next_s.addr[c][7:0] = dat_i[7:0]; // [R4] [R16] [R17]
                    end
                end
                REG_ADDR_MID: begin
                    if (idle && !s.chain[c] && sel_i[0]) begin
                        next_s.addr[c][15:8] = dat_i[7:0]; // [R4] [R16] [R17]
                    end
                end
                REG_ADDR_BANK: begin
                    if (idle && !s.chain[c] && sel_i[0]) begin
                        next_s.addr[c][23:16] = dat_i[7:0]; // [R4] [R17]
                    end
                end
                REG_COUNT: begin
                    if (idle && !s.chain[c]) begin
                        if (sel_i[0]) next_s.cnt[c][7:0] = dat_i[7:0];
                        if (sel_i[1]) next_s.cnt[c][15:8] = dat_i[15:8];
                    end
                end
                REG_CUR_DESC: begin
                    if (idle) begin
                        if (sel_i[0]) next_s.cdp[c][7:0] = dat_i[7:0];
                        if (sel_i[1]) next_s.cdp[c][15:8] = dat_i[15:8];
                    end
                end
                // End pointer may move while running to extend the chain
                REG_END_DESC: begin
                    if (sel_i[0]) next_s.edp[c][7:0] = dat_i[7:0];
                    if (sel_i[1]) next_s.edp[c][15:8] = dat_i[15:8];
                end
                REG_DESC_BASE: begin
                    if (idle && sel_i[0]) begin
                        next_s.cpb[c] = dat_i[7:0];
                    end
                end
                REG_COMMAND: begin
                    if (sel_i[0]) begin
                        if (dat_i[CMD_FRAME]) next_s.frame[c] = 1'b0;
                        if (dat_i[CMD_DONE]) next_s.done[c] = 1'b0; // [R22]
                        if (idle) begin
                            next_s.chain[c] = dat_i[CMD_CHAIN];
                            next_s.word[c]  = dat_i[CMD_WORD];
                        end
                        // Channel state moves, abort taking precedence
                        if (dat_i[CMD_ABORT]) begin
                            next_s.cst[c] = CH_INIT; // [R16]
                        end else if (dat_i[CMD_ENABLE]) begin
                            if (idle) begin
                                next_s.need[c] = next_s.chain[c];
                            end
                            next_s.cst[c] = CH_ENABLE; // [R16]
                        end else if (s.cst[c] == CH_ENABLE) begin
                            next_s.cst[c] = CH_HALT; // [R16]
                        end
                    end
                    if (sel_i[1]) begin
                        next_s.die[c] = dat_i[CMD_DONE_IE];
                        next_s.fie[c] = dat_i[CMD_FRAME_IE];
                    end
                end
                default: ;
            endcase
        end

        // Requests from buffer status; ties go to the lower channel
        for (int i = 0; i < NUM_CH; i++) begin
            want[i] = (s.cst[i] == CH_ENABLE) && // [R6]
                      (i[0] ? tx_space_i[i/2] : rx_ready_i[i/2]); // [R7] [R1]
            if (want[i] && (!found || s.prio[2*i +: 2] > best)) begin
                found = 1'b1; // [R23] [R8]
                best  = s.prio[2*i +: 2];
                win   = i[1:0];
            end
        end

        // Transfer engine; one memory cycle in flight at a time
        case (s.eng)
            E_IDLE: begin
                if (found) begin
                    next_s.gnt = win;
                    if (s.need[win] && s.cdp[win] == s.edp[win]) begin
                        next_s.done[win] = 1'b1; // [R20] [R12] [R9]
                        next_s.cst[win]  = CH_INIT;
                        next_s.need[win] = 1'b0;
                    end else if (s.need[win]) begin
                        // Descriptor fetch from base and current pointer
                        next_s.mem.req  = 1'b1; // [R13] [R14]
                        next_s.mem.we   = 1'b0;
                        next_s.mem.word = 1'b0;
                        next_s.mem.addr = {s.cpb[win], s.cdp[win]};
                        next_s.eng      = E_DESC0;
                    end else begin
                        // Word only while two or more bytes remain
                        if (s.word[win] && s.cnt[win] != SZ_BYTE) begin
                            sz = SZ_WORD; // [R5]
                        end
                        next_s.mem.req   = 1'b1;
                        next_s.mem.we    = ~win[0]; // [R2] [R21]
                        next_s.mem.word  = (sz == SZ_WORD);
                        next_s.mem.addr  = s.addr[win];
                        next_s.mem.wdata = rx_data_i[win[1]];
                        next_s.eng       = E_XFER; // [R10]
                    end
                end
            end
            E_XFER: begin
                if (mem_i.ack) begin
                    sz = s.mem.word ? SZ_WORD : SZ_BYTE;
                    next_s.mem.req = 1'b0;
                    next_s.addr[g] = s.addr[g] + {8'h0, sz}; // [R24] [R17]
                    next_s.cnt[g]  = s.cnt[g] - sz; // [R19]
                    if (g[0]) begin
                        next_s.txd = s.mem.word ? mem_i.rdata[15:0]
                                                : {8'h0, mem_i.rdata[7:0]};
                        next_s.txp[g[1]] = 1'b1; // [R2]
                    end else begin
                        rx_pop[g[1]] = 1'b1;
                        last = rx_last_i[g[1]];
                    end
                    if (next_s.cnt[g] == 16'h0000 || (s.chain[g] && last)) begin
                        if (!s.chain[g]) begin
                            next_s.done[g] = 1'b1; // [R3] [R19] [R22] [R9]
                            next_s.cst[g]  = CH_INIT;
                        end else begin
                            // Buffer finished; chain moves on to the next
                            next_s.need[g]   = 1'b1; // [R14] [R15]
                            next_s.frame[g]  = 1'b1; // [R9]
                            next_s.txl[g[1]] = g[0];
                        end
                    end
                    next_s.eng = E_IDLE;
                end
            end
            E_DESC0: begin
                // First descriptor word: next link and buffer length
                if (mem_i.ack) begin
                    next_s.dnext    = mem_i.rdata[31:16]; // [R13]
                    next_s.cnt[g]   = mem_i.rdata[15:0];
                    next_s.mem.addr = s.mem.addr + DESC_STEP;
                    next_s.eng      = E_DESC1;
                end
            end
            E_DESC1: begin
                // Second descriptor word: buffer start address
                if (mem_i.ack) begin
                    next_s.mem.req = 1'b0;
                    next_s.addr[g] = mem_i.rdata[23:0]; // [R14]
                    next_s.cdp[g]  = s.dnext;
                    next_s.need[g] = 1'b0;
                    next_s.eng     = E_IDLE;
                end
            end
            default: next_s.eng = E_IDLE;
        endcase
    end

    // State register; addresses clear too, though nothing relies on it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0; // [R18]
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state, except rx_pop_o from the next-state logic
    assign dat_o     = s.dat;
    assign ack_o     = s.ack;
    assign mem_o     = s.mem;
    assign rx_pop_o  = rx_pop;
    assign tx_data_o = s.txd;
    assign tx_push_o = s.txp;
    assign tx_last_o = s.txl;
    assign irq_o     = (s.done & s.die) | (s.frame & s.fie); // [R22] [R9]

endmodule : serial_channel_dma_controller
